/* design/idpa_input_filter.sv */
// discrete input debounce and front-panel pot averaging, top level
`timescale 1ns/10ps

// What this block does
// - debounce settable 0.5 to 20 ms
// - each setting unit is one 0.5 ms step
// - clamp setting to 1..40
// - filter time word resets to 6
// - debounce accurate within half a millisecond
// - new setting takes effect while running
// - long steady level always gets through
// - inputs scanned lowest index first
// - two pot results, own filter each
// - one sample per sweep, mean when done
// - average two to the three-bit exponent
// - result withheld until window; exponent 0 immediate
// - exponent word resets to 4
module idpa_input_filter
#(
  parameter int STEP_CYC = idpa_pkg::STEP_CYCLES
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [idpa_pkg::ADDR_W-1:0] addr_i,
  input wire logic [idpa_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [idpa_pkg::DATA_W-1:0] rdata_o,
  input wire logic [idpa_pkg::N_IN-1:0] disc_raw_i,
  output logic [idpa_pkg::N_IN-1:0] disc_filtered_o,
  input wire logic sweep_tick_i,
  input wire logic [idpa_pkg::SMP_W-1:0] upper_pot_sample_i,
  input wire logic [idpa_pkg::SMP_W-1:0] lower_pot_sample_i,
  output logic [idpa_pkg::SMP_W-1:0] upper_pot_result_o,
  output logic [idpa_pkg::SMP_W-1:0] lower_pot_result_o,
  output logic [1:0] pot_updated_o
);
  import idpa_pkg::*;

  // ---------------------------------------------------------------
  // clamp of the filter time word
  // ---------------------------------------------------------------
  function automatic logic [DB_CNT_W-1:0] clamp_steps
  (
    input logic [DATA_W-1:0] word
  );
    logic [DATA_W-1:0] v;
    v = word;
    if (word < FILT_MIN)
      v = FILT_MIN;
    else if (word > FILT_MAX)
      v = FILT_MAX;
    return v[DB_CNT_W-1:0];
  endfunction : clamp_steps

  logic [DATA_W-1:0] discrete_filter_time_word_ff;
  logic [DATA_W-1:0] pot_average_exponent_word_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [STEP_CNT_W-1:0] step_cnt_ff;
  logic step_ff;
  idpa_scan_t scan_ff;
  logic [IDX_W-1:0] idx_ff;
  logic [DB_CNT_W-1:0] db_cnt_ff [N_IN];
  logic [N_IN-1:0] filt_ff;
  logic [DB_CNT_W-1:0] limit;
  logic step_wrap;

  // carriers for the two pot channels: 0 upper, 1 lower
  idpa_avg_if av[2] ();

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      discrete_filter_time_word_ff <= FILT_TIME_RST;
      pot_average_exponent_word_ff <= AVG_EXP_RST;
    end
    else if (wr_i)
    begin
      if (addr_i == ADDR_FILT_TIME)
        discrete_filter_time_word_ff <= wdata_i;
      else if (addr_i == ADDR_AVG_EXP)
        pot_average_exponent_word_ff <= wdata_i;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the strobe only
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_ff <= '0;
    else if (!rd_i)
      rdata_ff <= '0;
    else if (addr_i == ADDR_FILT_TIME)
      rdata_ff <= discrete_filter_time_word_ff;
    else if (addr_i == ADDR_AVG_EXP)
      rdata_ff <= pot_average_exponent_word_ff;
    else if (addr_i == ADDR_UPPER_POT)
      rdata_ff <= av[0].result;
    else if (addr_i == ADDR_LOWER_POT)
      rdata_ff <= av[1].result;
    else if (addr_i == ADDR_DISC_STATE)
      rdata_ff <= DATA_W'(filt_ff);
    else if (addr_i == ADDR_STATUS)
      rdata_ff <= DATA_W'(scan_ff == SCAN_RUN) << STAT_SCAN_BIT;
    else
      rdata_ff <= '0;
  end

  assign rdata_o = rdata_ff;

  // ---------------------------------------------------------------
  // 0.5 ms step timer
  // ---------------------------------------------------------------
  assign step_wrap = (step_cnt_ff == STEP_CNT_W'(STEP_CYC - 1));

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      step_cnt_ff <= '0;
      step_ff <= 1'b0;
    end
    else
    begin
      step_ff <= step_wrap;
      if (step_wrap)
        step_cnt_ff <= '0;
      else
        step_cnt_ff <= step_cnt_ff + 20'h00001;
    end
  end

  // ---------------------------------------------------------------
  // input scan sequencer, one input per clock
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      scan_ff <= SCAN_IDLE;
      idx_ff <= '0;
    end
    else
    begin
      case (scan_ff)
        SCAN_IDLE:
        begin
          idx_ff <= '0;
          if (step_ff)
            scan_ff <= SCAN_RUN;
        end
        SCAN_RUN:
        begin
          idx_ff <= idx_ff + 3'h1;
          if (idx_ff == IDX_W'(N_IN - 1))
            scan_ff <= SCAN_IDLE;
        end
        default:
        begin
          scan_ff <= SCAN_IDLE;
          idx_ff <= '0;
        end
      endcase
    end
  end

  // setting read live on every visit
  assign limit = clamp_steps(discrete_filter_time_word_ff);

  // ---------------------------------------------------------------
  // per-input debounce counters
  // ---------------------------------------------------------------
  for (genvar g = 0; g < N_IN; g++)
  begin : g_db
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        db_cnt_ff[g] <= '0;
        filt_ff[g] <= 1'b0;
      end
      else if (scan_ff == SCAN_RUN && idx_ff == IDX_W'(g))
      begin
        if (disc_raw_i[g] == filt_ff[g])
          db_cnt_ff[g] <= '0;
        else if (db_cnt_ff[g] + 6'h01 >= limit)
        begin
          filt_ff[g] <= disc_raw_i[g];
          db_cnt_ff[g] <= '0;
        end
        else
          db_cnt_ff[g] <= db_cnt_ff[g] + 6'h01;
      end
    end
  end

  assign disc_filtered_o = filt_ff;

  // ---------------------------------------------------------------
  // pot averaging channels: 0 upper, 1 lower
  // ---------------------------------------------------------------
  assign av[0].sample = upper_pot_sample_i;
  assign av[1].sample = lower_pot_sample_i;

  for (genvar c = 0; c < 2; c++)
  begin : g_pot
    assign av[c].sweep = sweep_tick_i;
    assign av[c].exponent =
      pot_average_exponent_word_ff[EXP_LSB +: EXP_W];
    idpa_pot_avg u_avg
    (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .av(av[c])
    );
    assign pot_updated_o[c] = av[c].updated;
  end

  assign upper_pot_result_o = av[0].result;
  assign lower_pot_result_o = av[1].result;

endmodule : idpa_input_filter

/* design/idpa_pkg.sv */
// shared constants for the input debounce and pot averager
package idpa_pkg;

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_FILT_TIME = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_AVG_EXP = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_UPPER_POT = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_LOWER_POT = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_DISC_STATE = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h5;

  // ---------------------------------------------------------------
  // reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] FILT_TIME_RST = 16'h0006;
  localparam logic [DATA_W-1:0] AVG_EXP_RST = 16'h0004;
  localparam int EXP_LSB = 0;
  localparam int EXP_W = 3;
  localparam int STAT_SCAN_BIT = 0;

  // ---------------------------------------------------------------
  // debounce
  // ---------------------------------------------------------------
  localparam int N_IN = 8;
  localparam int IDX_W = 3;
  localparam int DB_CNT_W = 6;
  localparam logic [DATA_W-1:0] FILT_MIN = 16'h0001;
  localparam logic [DATA_W-1:0] FILT_MAX = 16'h0028;

  // ---------------------------------------------------------------
  // timing: one filter step of 0.5 ms at 50 MHz
  // ---------------------------------------------------------------
  localparam int STEP_NS = 500000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam int STEP_CNT_W = 20;

  // ---------------------------------------------------------------
  // averaging
  // ---------------------------------------------------------------
  localparam int SMP_W = 16;
  localparam int ACC_W = SMP_W + 7;
  localparam int SWP_CNT_W = 8;

  typedef enum logic [1:0]
  {
    SCAN_IDLE = 2'b01,
    SCAN_RUN = 2'b10
  } idpa_scan_t;

endpackage : idpa_pkg

/* design/idpa_avg_if.sv */
// carrier between the top and one averaging channel
`timescale 1ns/10ps
interface idpa_avg_if;
  import idpa_pkg::*;
  logic [SMP_W-1:0] sample;
  logic sweep;
  logic [EXP_W-1:0] exponent;
  logic [SMP_W-1:0] result;
  logic updated;

  modport ctl
  (
    output sample,
    output sweep,
    output exponent,
    input result,
    input updated
  );
  modport avg
  (
    input sample,
    input sweep,
    input exponent,
    output result,
    output updated
  );
endinterface : idpa_avg_if

/* design/idpa_pot_avg.sv */
// one power-of-two averaging channel
`timescale 1ns/10ps
module idpa_pot_avg
(
  input wire logic clk_i,
  input wire logic reset_i,
  idpa_avg_if.avg av
);
  import idpa_pkg::*;

  logic [ACC_W-1:0] acc_ff;
  logic [SWP_CNT_W-1:0] cnt_ff;
  logic [SMP_W-1:0] result_ff;
  logic updated_ff;
  logic [ACC_W-1:0] nxt_acc;
  logic [SWP_CNT_W:0] nxt_cnt;
  logic [SWP_CNT_W:0] target;
  logic window_done;

  // ---------------------------------------------------------------
  // window arithmetic
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_acc = acc_ff + ACC_W'(av.sample);
    nxt_cnt = {1'b0, cnt_ff} + 9'h001;
    target = 9'h001 << av.exponent;
    window_done = (nxt_cnt >= target);
  end

  // ---------------------------------------------------------------
  // accumulate one sample per sweep
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      acc_ff <= '0;
      cnt_ff <= '0;
    end
    else if (av.sweep)
    begin
      if (window_done)
      begin
        acc_ff <= '0;
        cnt_ff <= '0;
      end
      else
      begin
        acc_ff <= nxt_acc;
        cnt_ff <= nxt_cnt[SWP_CNT_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // result word, written only when a window closes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result_ff <= '0;
      updated_ff <= 1'b0;
    end
    else
    begin
      updated_ff <= av.sweep && window_done;
      if (av.sweep && window_done)
        result_ff <= SMP_W'(nxt_acc >> av.exponent);
    end
  end

  assign av.result = result_ff;
  assign av.updated = updated_ff;

endmodule : idpa_pot_avg

/* test/idpa_input_filter_checker.sv */
// port checker for the input debounce and pot averager
`timescale 1ns/10ps
module idpa_input_filter_checker
#(
  parameter int STEP_CYC = 10
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic rd_i,
  input wire logic [idpa_pkg::DATA_W-1:0] rdata_o,
  input wire logic [idpa_pkg::N_IN-1:0] disc_raw_i,
  input wire logic [idpa_pkg::N_IN-1:0] disc_filtered_o,
  input wire logic sweep_tick_i,
  input wire logic [idpa_pkg::SMP_W-1:0] upper_pot_result_o,
  input wire logic [idpa_pkg::SMP_W-1:0] lower_pot_result_o,
  input wire logic [1:0] pot_updated_o
);
  import idpa_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("read data not zero outside read");
  a_upper_upd_sweep: assert property
    (pot_updated_o[0] |-> $past(sweep_tick_i))
    else $error("upper update without sweep");
  a_lower_upd_sweep: assert property
    (pot_updated_o[1] |-> $past(sweep_tick_i))
    else $error("lower update without sweep");
  a_upper_result_hold: assert property
    (!pot_updated_o[0] |-> $stable(upper_pot_result_o))
    else $error("upper result moved without update");
  a_lower_result_hold: assert property
    (!pot_updated_o[1] |-> $stable(lower_pot_result_o))
    else $error("lower result moved without update");
  a_pot_update_pair: assert property
    (pot_updated_o[0] == pot_updated_o[1])
    else $error("pot channels out of step");
  a_filt_one_visit: assert property
    ($onehot0(disc_filtered_o ^ $past(disc_filtered_o)))
    else $error("more than one input switched in a cycle");
  a_filt_toward_raw: assert property
    (((disc_filtered_o ^ $past(disc_filtered_o))
    & (disc_filtered_o ^ $past(disc_raw_i))) == 8'h00)
    else $error("filtered input switched away from raw level");
endmodule : idpa_input_filter_checker

/* test/idpa_field_model.sv */
// front-panel pots and sweep source facing the block
`timescale 1ns/10ps
module idpa_field_model
(
  input wire logic req_i,
  input wire logic [idpa_pkg::SMP_W-1:0] up_i,
  input wire logic [idpa_pkg::SMP_W-1:0] lo_i,
  output logic sweep_tick_o,
  output logic [idpa_pkg::SMP_W-1:0] upper_o,
  output logic [idpa_pkg::SMP_W-1:0] lower_o
);
  import idpa_pkg::*;
  // samples only hold at the sweep; junk otherwise
  assign sweep_tick_o = req_i;
  assign upper_o = req_i ? up_i : ~up_i;
  assign lower_o = req_i ? lo_i : ~lo_i;
endmodule : idpa_field_model

/* test/test_idpa_input_filter.sv */
// testbench for the input debounce and pot averager
`timescale 1ns/10ps
module test_idpa_input_filter;
  import idpa_pkg::*;
  localparam int S = 16;
  logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, req = 0;
  logic [ADDR_W-1:0] addr_i = 3'h0;
  logic [DATA_W-1:0] wdata_i = 16'h0000, rdata_o;
  logic [N_IN-1:0] raw = 8'h00, filt;
  logic [SMP_W-1:0] up = 16'h0000, lo = 16'h0000, us, ls, ur, lr;
  logic tick;
  logic [1:0] upd;
  int n_errors = 0, n_compared = 0, k;
  always #10 clk_i = ~clk_i;
  idpa_field_model idpa_field_model_i (.req_i(req), .up_i(up), .lo_i(lo),
    .sweep_tick_o(tick), .upper_o(us), .lower_o(ls));
  idpa_input_filter #(.STEP_CYC(S)) idpa_input_filter_i (.clk_i(clk_i),
    .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .disc_raw_i(raw), .disc_filtered_o(filt),
    .sweep_tick_i(tick), .upper_pot_sample_i(us), .lower_pot_sample_i(ls),
    .upper_pot_result_o(ur), .lower_pot_result_o(lr), .pot_updated_o(upd));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask : rd
  task automatic sw(input logic [15:0] u, input logic [15:0] l);
    @(posedge clk_i);
    req <= 1'b1; up <= u; lo <= l;
    @(posedge clk_i);
    req <= 1'b0;
    #1;
  endtask : sw
  // apply setting, flip all inputs, time each switch
  task automatic db(input logic [15:0] w, input logic [7:0] v, input int n);
    int t[8];
    int c;
    int b;
    logic ok;
    wr(ADDR_FILT_TIME, w);
    @(posedge clk_i);
    raw <= v;
    for (b = 0; b < 8; b++) t[b] = -1;
    for (c = 0; c < (n + 1) * S + 12; c++)
    begin
      @(posedge clk_i);
      #1;
      for (b = 0; b < 8; b++) if (t[b] < 0 && filt[b] === v[b]) t[b] = c;
    end
    for (b = 0; b < 8; b++)
    begin
      ok = t[b] >= (n - 1) * S && t[b] <= (n + 1) * S + 10;
      chk({15'h0, ok}, 16'h1);
      if (b > 0) chk({15'h0, t[b] > t[b-1]}, 16'h1);
    end
  endtask : db
  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    #1000000;
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(ADDR_FILT_TIME, 16'h0006);
    rd(ADDR_AVG_EXP, 16'h0004);
    rd(3'h6, 16'h0000);
    wr(ADDR_UPPER_POT, 16'h1234);
    rd(ADDR_UPPER_POT, 16'h0000);
    for (k = 1; k <= 16; k++)
    begin
      sw(k[15:0], 16'(2 * k));
      if (k == 15) chk(ur, 16'h0000);
    end
    chk(ur, 16'h0008);
    chk(lr, 16'h0011);
    chk({14'h0, upd}, 16'h0003);
    wr(ADDR_AVG_EXP, 16'hFFF8);
    sw(16'h0005, 16'h0007);
    chk(ur, 16'h0005);
    chk(lr, 16'h0007);
    wr(ADDR_AVG_EXP, 16'h0002);
    sw(16'h0001, 16'h000A);
    sw(16'h0002, 16'h0014);
    sw(16'h0003, 16'h001E);
    chk(ur, 16'h0005);
    sw(16'h0006, 16'h0028);
    chk(ur, 16'h0003);
    rd(ADDR_LOWER_POT, 16'h0019);
    db(16'h0000, 8'hFF, 1);
    db(16'h0002, 8'h00, 2);
    db(16'h002D, 8'hFF, 40);
    rd(ADDR_FILT_TIME, 16'h002D);
    wr(ADDR_FILT_TIME, 16'h0006);
    raw <= 8'h00;
    repeat (3 * S) @(posedge clk_i);
    raw <= 8'hFF;
    repeat (8 * S) @(posedge clk_i);
    rd(ADDR_DISC_STATE, 16'h00FF);
    raw <= 8'h00;
    repeat (8 * S) @(posedge clk_i);
    rd(ADDR_DISC_STATE, 16'h0000);
    summarize();
  end
endmodule : test_idpa_input_filter
bind idpa_input_filter idpa_input_filter_checker #(.STEP_CYC(STEP_CYC))
  idpa_input_filter_checker_i
  (.clk_i(clk_i), .reset_i(reset_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .disc_raw_i(disc_raw_i), .disc_filtered_o(disc_filtered_o),
  .sweep_tick_i(sweep_tick_i), .upper_pot_result_o(upper_pot_result_o),
  .lower_pot_result_o(lower_pot_result_o), .pot_updated_o(pot_updated_o));
